// *** mio_cfg.svh ***
// offsets, field positions and reset values of the muxed port
`ifndef MIO_CFG_SVH
`define MIO_CFG_SVH

// ==================================================================
// register offsets
`define MIO_OFS_PIN_LEVEL     3'h0
`define MIO_OFS_OUTPUT_LATCH  3'h1
`define MIO_OFS_PIN_DIRECTION 3'h2
`define MIO_OFS_CMP_CTRL      3'h3
`define MIO_OFS_ANA_CFG       3'h4
`define MIO_OFS_VREF_CTRL     3'h5
`define MIO_OFS_SEG_GRP_TWO   3'h6
`define MIO_OFS_SEG_GRP_THREE 3'h7

// ==================================================================
// reset values
`define MIO_RST_LATCH     8'h00
`define MIO_RST_DIRECTION 8'hfe
`define MIO_RST_CMP_CTRL  8'h00
`define MIO_RST_ANA_CFG   8'h00
`define MIO_RST_VREF_CTRL 8'h00
`define MIO_RST_SEG       8'h00

// ==================================================================
// field positions and codes
`define MIO_PORT_MASK     8'hfe
`define MIO_CMP_MODE_MSB  2
`define MIO_CMP_MODE_LSB  0
`define MIO_CMP_TWO_RES   7
`define MIO_CMP_ONE_RES   6
`define MIO_CMP_WR_MASK   8'h3f
`define MIO_CMP_MODE_OFF  3'h7
`define MIO_CMP_MODE_OUTS 3'h3
`define MIO_ANA_PCFG_MSB  3
`define MIO_ANA_WR_MASK   8'h3f
`define MIO_ANA_TOP_CHAN  5'he
`define MIO_VREF_OE_BIT   6
`define MIO_SEG2_LOW_BIT  3
`define MIO_SEG3_LOW_BIT  0
`define MIO_VREF_PIN      5
`define MIO_SS_PIN        7
`define MIO_CMP_IN_LO     3
`define MIO_CMP_IN_HI     6

`endif

// *** mio_pkg.sv ***
// types shared by the muxed port and its users
package mio_pkg;

	// ==================================================================
	// register bus request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} mio_req_s;

	// ==================================================================
	// pad control, bit 0 unused
	typedef struct packed {
		logic [7:0] drive;
		logic [7:0] oe;
	} mio_pad_s;

	typedef logic [3:0] mio_chan_t;

endpackage : mio_pkg

// *** mio_sync.sv ***
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module mio_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;

	// first stage is read only by the second
	always_comb begin
		nxt_meta = d;
		nxt_q    = meta_ff;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= nxt_meta;
			q_ff    <= nxt_q;
		end
	end

	assign q = q_ff;

endmodule : mio_sync

// *** mio_port.sv ***
// seven-pin general-purpose port with analog, comparator, reference, select and segment sharing
`timescale 1ns/10ps
`include "mio_cfg.svh"

module mio_port (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire mio_pkg::mio_req_s bus_req,
	output logic [7:0]             rdata,
	input  wire logic [7:0]        pad_in,
	output mio_pkg::mio_pad_s      pad_ctl,
	input  wire logic              cmp_one_result,
	input  wire logic              cmp_two_result,
	output logic [7:0]             analog_sel,
	output logic [2:0]             cmp_mode,
	output logic                   cmp_active,
	output logic                   ref_out_en,
	output logic                   ss_n,
	output logic [7:0]             seg_own
);

	// ==================================================================
	// decode helpers
	function automatic mio_pkg::mio_chan_t chan_of(input int pin);
		mio_pkg::mio_chan_t c;
		c = 4'h0;
		case (pin)
			1:       c = 4'h6;
			2:       c = 4'h7;
			7:       c = 4'h5;
			default: c = 4'(pin + 5);
		endcase
		return c;
	endfunction : chan_of

	// higher config codes turn channels digital from the top down
	function automatic logic chan_analog(input logic [3:0] pcfg,
	                                     input mio_pkg::mio_chan_t ch);
		return {1'b0, pcfg} <= (`MIO_ANA_TOP_CHAN - {1'b0, ch});
	endfunction : chan_analog

	// comparator mode field, read by several decoders
	function automatic logic [2:0] cmp_mode_of(input logic [7:0] ctrl);
		return ctrl[`MIO_CMP_MODE_MSB:`MIO_CMP_MODE_LSB];
	endfunction : cmp_mode_of

	// bit 0 has no pin behind it, so it is dropped on every way in and out
	function automatic logic [7:0] port_bits(input logic [7:0] v);
		return v & `MIO_PORT_MASK;
	endfunction : port_bits

	// in output mode a comparator result wins over the latch
	function automatic logic pick_drive(input logic outs,
	                                    input logic res,
	                                    input logic lat);
		return outs ? res : lat;
	endfunction : pick_drive

	// ==================================================================
	// registers
	logic [7:0] latch_ff;
	logic [7:0] nxt_latch;
	logic [7:0] dir_ff;
	logic [7:0] nxt_dir;
	logic [7:0] cmp_ctrl_ff;
	logic [7:0] nxt_cmp_ctrl;
	logic [7:0] ana_cfg_ff;
	logic [7:0] nxt_ana_cfg;
	logic [7:0] vref_ctrl_ff;
	logic [7:0] nxt_vref_ctrl;
	logic [7:0] seg2_ff;
	logic [7:0] nxt_seg2;
	logic [7:0] seg3_ff;
	logic [7:0] nxt_seg3;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// ==================================================================
	// pin side state
	logic [7:0] pin_sync;
	logic [7:0] ana_pin;
	logic [7:0] seg_pin;
	logic [7:0] dig_in_en;
	logic [7:0] dig_out_en;
	logic [7:0] drv_val;
	logic [7:0] level_view;
	logic [7:0] drive_ff;
	logic [7:0] nxt_drive;
	logic [7:0] oe_ff;
	logic [7:0] nxt_oe;
	logic [7:0] ana_ff;
	logic [7:0] nxt_ana;
	logic       ss_n_ff;
	logic       nxt_ss_n;
	logic       cmp_on;
	logic       cmp_outs;
	logic       vref_oe;

	// pins are asynchronous, two flops before any use
	mio_sync #(
		.W (8)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (pad_in),
		.q     (pin_sync)
	);

	assign cmp_on   = cmp_mode_of(cmp_ctrl_ff) != `MIO_CMP_MODE_OFF;
	assign cmp_outs = cmp_mode_of(cmp_ctrl_ff) == `MIO_CMP_MODE_OUTS;
	assign vref_oe  = vref_ctrl_ff[`MIO_VREF_OE_BIT];

	// segment enables 19..23 sit high in group two, 24..25 low in group three
	assign seg_pin = {seg3_ff[`MIO_SEG3_LOW_BIT+1:`MIO_SEG3_LOW_BIT],
	                  seg2_ff[7:`MIO_SEG2_LOW_BIT], 1'b0};

	// ==================================================================
	// per-pin ownership
	// strongest first: segment, reference output, then direction and latch;
	// the analog selection only ever gates the input side
	assign ana_pin[0]    = 1'b0;
	assign dig_in_en[0]  = 1'b0;
	assign dig_out_en[0] = 1'b0;
	assign drv_val[0]    = 1'b0;

	genvar gi;
	generate
		for (gi = 1; gi < 8; gi++) begin : g_pin
			localparam bit IS_CMP_IN = (gi >= `MIO_CMP_IN_LO) && (gi <= `MIO_CMP_IN_HI);
			localparam bit IS_VREF   = (gi == `MIO_VREF_PIN);
			logic ref_block;
			logic cmp_block;

			assign ana_pin[gi] = chan_analog(ana_cfg_ff[`MIO_ANA_PCFG_MSB:0],
			                                 chan_of(gi));
			assign ref_block   = IS_VREF && vref_oe;
			// comparator inputs hold the pin analog until the comparators are off
			assign cmp_block   = IS_CMP_IN && cmp_on;
			// a segment takes the pin whatever the direction says
			assign dig_in_en[gi]  = !ana_pin[gi] && !cmp_block && !ref_block
			                        && !seg_pin[gi];
			// analog selection leaves the output path alone
			assign dig_out_en[gi] = !dir_ff[gi] && !ref_block && !seg_pin[gi];

			if (gi == 1) begin : g_c2
				assign drv_val[gi] = pick_drive(cmp_outs, cmp_two_result, latch_ff[gi]);
			end else if (gi == 2) begin : g_c1
				assign drv_val[gi] = pick_drive(cmp_outs, cmp_one_result, latch_ff[gi]);
			end else begin : g_lat
				assign drv_val[gi] = latch_ff[gi];
			end
		end
	endgenerate

	// schmitt buffering lives in the pad; here the digital view is gated only
	// level reads lag the pin by the two sync flops and the read register
	assign level_view = pin_sync & dig_in_en;

	// ==================================================================
	// pad drive and side outputs
	always_comb begin
		nxt_drive = drv_val & dig_out_en;
		nxt_oe    = dig_out_en;
		// a segment drive makes the pin useless to the converter as well
		nxt_ana   = ana_pin & ~seg_pin;
		// select sees the pin only as a digital input; idle high otherwise
		nxt_ss_n  = 1'b1;
		if (dir_ff[`MIO_SS_PIN] && !seg_pin[`MIO_SS_PIN] && !ana_pin[`MIO_SS_PIN]) begin
			nxt_ss_n = pin_sync[`MIO_SS_PIN];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_ff <= 8'h00;
			oe_ff    <= 8'h00;
			ana_ff   <= 8'h00;
			ss_n_ff  <= 1'b1;
		end else begin
			drive_ff <= nxt_drive;
			oe_ff    <= nxt_oe;
			ana_ff   <= nxt_ana;
			ss_n_ff  <= nxt_ss_n;
		end
	end

	// pad controls leave from flops so a register write cannot glitch a pin
	assign pad_ctl       = '{drive: drive_ff, oe: oe_ff};
	assign analog_sel    = ana_ff;
	assign ss_n          = ss_n_ff;
	assign seg_own       = seg_pin;
	assign cmp_mode      = cmp_mode_of(cmp_ctrl_ff);
	assign cmp_active    = cmp_on;
	assign ref_out_en    = vref_oe;

	// ==================================================================
	// register writes
	// upper comparator and analog bits have no function and are not stored
	always_comb begin
		nxt_latch     = latch_ff;
		nxt_dir       = dir_ff;
		nxt_cmp_ctrl  = cmp_ctrl_ff;
		nxt_ana_cfg   = ana_cfg_ff;
		nxt_vref_ctrl = vref_ctrl_ff;
		nxt_seg2      = seg2_ff;
		nxt_seg3      = seg3_ff;
		if (bus_req.wr) begin
			case (bus_req.addr)
				`MIO_OFS_PIN_LEVEL: begin
					nxt_latch = port_bits(bus_req.wdata);
				end
				`MIO_OFS_OUTPUT_LATCH: begin
					nxt_latch = port_bits(bus_req.wdata);
				end
				`MIO_OFS_PIN_DIRECTION: begin
					nxt_dir = port_bits(bus_req.wdata);
				end
				`MIO_OFS_CMP_CTRL: begin
					nxt_cmp_ctrl = bus_req.wdata & `MIO_CMP_WR_MASK;
				end
				`MIO_OFS_ANA_CFG: begin
					nxt_ana_cfg = bus_req.wdata & `MIO_ANA_WR_MASK;
				end
				`MIO_OFS_VREF_CTRL: begin
					nxt_vref_ctrl = bus_req.wdata;
				end
				`MIO_OFS_SEG_GRP_TWO: begin
					nxt_seg2 = bus_req.wdata;
				end
				`MIO_OFS_SEG_GRP_THREE: begin
					nxt_seg3 = bus_req.wdata;
				end
				default: begin
					nxt_latch = latch_ff;
				end
			endcase
		end
	end

	// ==================================================================
	// register reads, data in the cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`MIO_OFS_PIN_LEVEL:     nxt_rdata = port_bits(level_view);
				`MIO_OFS_OUTPUT_LATCH:  nxt_rdata = latch_ff;
				`MIO_OFS_PIN_DIRECTION: nxt_rdata = dir_ff;
				`MIO_OFS_CMP_CTRL: begin
					// result bits are read live; their stored copies stay zero
					nxt_rdata = cmp_ctrl_ff;
					nxt_rdata[`MIO_CMP_TWO_RES] = cmp_two_result;
					nxt_rdata[`MIO_CMP_ONE_RES] = cmp_one_result;
				end
				`MIO_OFS_ANA_CFG:       nxt_rdata = ana_cfg_ff;
				`MIO_OFS_VREF_CTRL:     nxt_rdata = vref_ctrl_ff;
				`MIO_OFS_SEG_GRP_TWO:   nxt_rdata = seg2_ff;
				`MIO_OFS_SEG_GRP_THREE: nxt_rdata = seg3_ff;
				default:                nxt_rdata = 8'h00;
			endcase
		end
	end

	// analog config resets to all-analog, so pins 7..1 read zero after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff     <= `MIO_RST_LATCH;
			dir_ff       <= `MIO_RST_DIRECTION;
			cmp_ctrl_ff  <= `MIO_RST_CMP_CTRL;
			ana_cfg_ff   <= `MIO_RST_ANA_CFG;
			vref_ctrl_ff <= `MIO_RST_VREF_CTRL;
			seg2_ff      <= `MIO_RST_SEG;
			seg3_ff      <= `MIO_RST_SEG;
			rdata_ff     <= 8'h00;
		end else begin
			latch_ff     <= nxt_latch;
			dir_ff       <= nxt_dir;
			cmp_ctrl_ff  <= nxt_cmp_ctrl;
			ana_cfg_ff   <= nxt_ana_cfg;
			vref_ctrl_ff <= nxt_vref_ctrl;
			seg2_ff      <= nxt_seg2;
			seg3_ff      <= nxt_seg3;
			rdata_ff     <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;

endmodule : mio_port

// *** mio_port_asserts.sv ***
// concurrent checks on the ports of the muxed general-purpose port
`timescale 1ns/10ps
module mio_port_chk (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire mio_pkg::mio_req_s bus_req,
	input wire logic [7:0]        rdata,
	input wire mio_pkg::mio_pad_s pad_ctl,
	input wire logic              cmp_one_result,
	input wire logic              cmp_two_result,
	input wire logic [7:0]        analog_sel,
	input wire logic [2:0]        cmp_mode,
	input wire logic              cmp_active,
	input wire logic              ref_out_en,
	input wire logic              ss_n,
	input wire logic [7:0]        seg_own
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==================================================================
	// register reads
	property p_rd_idle; !bus_req.rd |=> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_bit0; bus_req.rd && bus_req.addr <= 3'h2 |=> !rdata[0]; endproperty
	a_rd_bit0: assert property (p_rd_bit0) else $error("bit 0 read as one");
	// analog_sel lags its register, so only steady configs are judged
	property p_ana_rd;
		bus_req.rd && bus_req.addr == 3'h0 && !$past(bus_req.wr)
			&& analog_sel == $past(analog_sel) |=> (rdata & $past(analog_sel)) == 8'h00;
	endproperty
	a_ana_rd: assert property (p_ana_rd) else $error("analog pin read as high");

	// ==================================================================
	// pin ownership
	property p_bit0; pad_ctl.oe[0] == 1'b0 && pad_ctl.drive[0] == 1'b0; endproperty
	a_bit0: assert property (p_bit0) else $error("bit 0 pad driven");
	property p_cmp_on; cmp_active == (cmp_mode != 3'h7); endproperty
	a_cmp_on: assert property (p_cmp_on) else $error("comparator activity wrong");
	property p_seg_own; 1'b1 |=> (pad_ctl.oe & $past(seg_own)) == 8'h00; endproperty
	a_seg_own: assert property (p_seg_own) else $error("segment pin driven");
	property p_seg_ss; seg_own[7] |=> ss_n; endproperty
	a_seg_ss: assert property (p_seg_ss) else $error("select active under segment");
	property p_ref; ref_out_en |=> !pad_ctl.oe[5]; endproperty
	a_ref: assert property (p_ref) else $error("reference pin driven");
	property p_cmp_two;
		(cmp_mode == 3'h3 && !seg_own[1]) ##1 pad_ctl.oe[1]
			|-> pad_ctl.drive[1] == $past(cmp_two_result);
	endproperty
	a_cmp_two: assert property (p_cmp_two) else $error("pin 1 not comparator two");
	property p_cmp_one;
		(cmp_mode == 3'h3 && !seg_own[2]) ##1 pad_ctl.oe[2]
			|-> pad_ctl.drive[2] == $past(cmp_one_result);
	endproperty
	a_cmp_one: assert property (p_cmp_one) else $error("pin 2 not comparator one");
endmodule : mio_port_chk

bind mio_port mio_port_chk u_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
	.pad_ctl(pad_ctl), .cmp_one_result(cmp_one_result), .cmp_two_result(cmp_two_result),
	.analog_sel(analog_sel), .cmp_mode(cmp_mode), .cmp_active(cmp_active),
	.ref_out_en(ref_out_en), .ss_n(ss_n), .seg_own(seg_own));

// *** tb_top.sv ***
// self-checking bench for the muxed general-purpose port
`timescale 1ns/10ps
module tb_top;
	logic              clk;
	logic              rst_n;
	mio_pkg::mio_req_s bus_req;
	logic [7:0]        rdata;
	logic [7:0]        pad_in;
	mio_pkg::mio_pad_s pad_ctl;
	logic              cmp_one_result;
	logic              cmp_two_result;
	logic [7:0]        analog_sel;
	logic [2:0]        cmp_mode;
	logic              cmp_active;
	logic              ref_out_en;
	logic              ss_n;
	logic [7:0]        seg_own;
	int                mismatches;
	int                checks;
	logic [7:0]        codes [4] = '{8'h00, 8'h06, 8'h09, 8'h0f};
	logic [7:0]        sels  [4] = '{8'hfe, 8'h8e, 8'h80, 8'h00};

	mio_port u_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
		.pad_in(pad_in), .pad_ctl(pad_ctl), .cmp_one_result(cmp_one_result),
		.cmp_two_result(cmp_two_result), .analog_sel(analog_sel), .cmp_mode(cmp_mode),
		.cmp_active(cmp_active), .ref_out_en(ref_out_en), .ss_n(ss_n), .seg_own(seg_own));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// ==================================================================
	// bus tasks and comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd

	// covers the two-flop pin sync and the registered pad outputs
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// ==================================================================
	// scenarios
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		pad_in = 8'hff;
		cmp_one_result = 1'b0;
		cmp_two_result = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk(analog_sel, 8'hfe);
		chk(pad_ctl.oe, 8'h00);
		chk({7'h00, ss_n}, 8'h01);
		rd(3'h0, 8'h00);
		rd(3'h2, 8'hfe);
		rd(3'h1, 8'h00);
		wr(3'h1, 8'hff);
		rd(3'h1, 8'hfe);
		wr(3'h0, 8'h35);
		rd(3'h1, 8'h34);
		wr(3'h2, 8'h00);
		settle();
		chk(pad_ctl.oe, 8'hfe);
		chk(pad_ctl.drive, 8'h34);
		@(posedge clk);
		cmp_two_result <= 1'b1;
		wr(3'h3, 8'h03);
		settle();
		chk(pad_ctl.drive, 8'h32);
		chk({5'h00, cmp_mode}, 8'h03);
		rd(3'h3, 8'h83);
		for (int i = 0; i < 4; i++) begin
			wr(3'h4, codes[i]);
			settle();
			chk(analog_sel, sels[i]);
		end
		wr(3'h3, 8'h07);
		wr(3'h2, 8'hfe);
		@(posedge clk);
		pad_in <= 8'ha5;
		settle();
		chk({7'h00, cmp_active}, 8'h00);
		chk({7'h00, ss_n}, 8'h01);
		rd(3'h0, 8'ha4);
		@(posedge clk);
		pad_in <= 8'h5a;
		settle();
		chk({7'h00, ss_n}, 8'h00);
		wr(3'h3, 8'h00);
		settle();
		rd(3'h0, 8'h02);
		wr(3'h2, 8'h00);
		wr(3'h5, 8'h40);
		settle();
		chk(pad_ctl.oe, 8'hde);
		chk({7'h00, ref_out_en}, 8'h01);
		wr(3'h5, 8'h00);
		wr(3'h7, 8'h03);
		settle();
		chk(seg_own, 8'hc0);
		chk(pad_ctl.oe, 8'h3e);
		wr(3'h6, 8'hf8);
		settle();
		chk(seg_own, 8'hfe);
		chk(pad_ctl.oe, 8'h00);
		// a second reset in mid-run must bring back the all-analog state
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk(analog_sel, 8'hfe);
		chk(pad_ctl.oe, 8'h00);
		chk(seg_own, 8'h00);
		rd(3'h0, 8'h00);
		print_verdict();
	end

	// the sequence needs about a hundred cycles; this bound of 2000 cycles is far beyond it
	initial begin
		#(2000 * 50);
		mismatches++;
		print_verdict();
	end
endmodule : tb_top
